// *** rtl/drt_params.svh ***
// constants of the dual reload down timer block
// Overview of operation
// - each timer holds a 32-bit software start value loaded on init or reload
// - start value c gives one interrupt every c+1 prescaled ticks
// - live-count pair reads back the present counter value
// - writing live count gives a one-off delay, then start value periods resume
// - each timer drives its own interrupt request, raised on underflow past zero
// - timer 0 dispatches through vector slot 0x26, timer 1 through 0x27
// - enabled timer decrements per tick, interrupts, reloads and keeps counting
// - shared 8-bit divider d gives a tick at master rate over d+1
// - enable bit 1 runs timer 1, bit 0 runs timer 0, one means on
`ifndef DRT_PARAMS_SVH
`define DRT_PARAMS_SVH
`define DRT_ADDR_W 8
`define DRT_OFS_CONFIG 8'h30
`define DRT_OFS_ENABLE 8'h31
`define DRT_OFS_T0_RELOAD_LO 8'h34
`define DRT_OFS_T0_RELOAD_HI 8'h35
`define DRT_OFS_T0_COUNT_LO 8'h36
`define DRT_OFS_T0_COUNT_HI 8'h37
`define DRT_OFS_T1_RELOAD_LO 8'h38
`define DRT_OFS_T1_RELOAD_HI 8'h39
`define DRT_OFS_T1_COUNT_LO 8'h3A
`define DRT_OFS_T1_COUNT_HI 8'h3B
`define DRT_OFS_IRQ_STATUS 8'h3C
`define DRT_OFS_IRQ_MASK 8'h3D
`define DRT_OFS_VECTOR 8'h3E
`define DRT_VEC_T0 8'h26
`define DRT_VEC_T1 8'h27
`define DRT_RST_CONFIG 8'h00
`define DRT_RST_ENABLE 2'h0
`define DRT_RST_VALUE 32'h0000_0000
`define DRT_RST_MASK 2'h0
`define DRT_RST_STATUS 2'h0
`define DRT_EN_T0_BIT 0
`define DRT_EN_T1_BIT 1
`endif

// *** rtl/drt_pkg.sv ***
// types of the dual reload down timer block
package drt_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } drt_bus_req_t;
    typedef struct packed {
        logic [1:0] irq;
        logic [7:0] vector;
    } drt_irq_out_t;
endpackage : drt_pkg

// *** rtl/drt_timer.sv ***
// dual 32-bit reload down timer with shared prescaler and register port
//
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "drt_params.svh"
module drt_timer (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    // register port
    input wire drt_pkg::drt_bus_req_t BUS_REQ,
    output logic [15:0] RDATA,
    // interrupts
    output logic [1:0] TIMER_IRQ,
    output logic IRQ,
    output logic [7:0] IRQ_VECTOR
);
    import drt_pkg::*;

    logic [7:0] tick_prescale_divider_r;
    logic [7:0] prescale_cnt_r;
    logic tick;
    logic [1:0] run_bits_r;
    logic [1:0] run_prev_r;
    logic [31:0] reload_r [2];
    logic [31:0] timer_live_count_r [2];
    logic [1:0] underflow;
    logic [1:0] status_r;
    logic [1:0] mask_r;
    logic [7:0] vec_nxt;
    logic [1:0] clear_req;
    logic [1:0] status_nxt;
    logic [1:0] mask_nxt;

    function automatic logic [31:0] put_half(input logic [31:0] v, input logic hi,
                                              input logic [15:0] d);
        put_half = hi ? {d, v[15:0]} : {v[31:16], d};
    endfunction : put_half

    function automatic logic [15:0] get_half(input logic [31:0] v, input logic hi);
        get_half = hi ? v[31:16] : v[15:0];
    endfunction : get_half

    // one decode for every register write, so all writers agree on a hit
    function automatic logic wr_hit(input drt_bus_req_t r, input logic [7:0] ofs);
        wr_hit = r.wr && (r.addr == ofs);
    endfunction : wr_hit

    // prescaler: tick once every d+1 master cycles
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            prescale_cnt_r <= 8'h00;
        end else if (prescale_cnt_r >= tick_prescale_divider_r) begin
            prescale_cnt_r <= 8'h00;
        end else begin
            prescale_cnt_r <= prescale_cnt_r + 8'h01;
        end
    end
    assign tick = (prescale_cnt_r >= tick_prescale_divider_r);

    // divider register, shared by both timers
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            tick_prescale_divider_r <= `DRT_RST_CONFIG;
        end else if (wr_hit(BUS_REQ, `DRT_OFS_CONFIG)) begin
            tick_prescale_divider_r <= BUS_REQ.wdata[7:0];
        end
    end

    // run bits, one per timer
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            run_bits_r <= `DRT_RST_ENABLE;
        end else if (wr_hit(BUS_REQ, `DRT_OFS_ENABLE)) begin
            run_bits_r[`DRT_EN_T0_BIT] <= BUS_REQ.wdata[`DRT_EN_T0_BIT];
            run_bits_r[`DRT_EN_T1_BIT] <= BUS_REQ.wdata[`DRT_EN_T1_BIT];
        end
    end

    // run bits one cycle late: a 0->1 step loads the start value before any count
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            run_prev_r <= `DRT_RST_ENABLE;
        end else begin
            run_prev_r <= run_bits_r;
        end
    end

    // interrupt mask; the interrupt output follows its next value, so it never lags
    assign mask_nxt = wr_hit(BUS_REQ, `DRT_OFS_IRQ_MASK) ? BUS_REQ.wdata[1:0] : mask_r;
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            mask_r <= `DRT_RST_MASK;
        end else begin
            mask_r <= mask_nxt;
        end
    end

    // underflow: counter at zero when an enabled tick arrives
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            underflow[i] = run_bits_r[i] && run_prev_r[i] && tick
                && (timer_live_count_r[i] == 32'h0000_0000);
        end
    end

    // the two timers; a bus write to the live count beats a same-cycle tick
    for (genvar g = 0; g < 2; g++) begin : g_tmr
        localparam logic [7:0] OFS_RL = g ? `DRT_OFS_T1_RELOAD_LO : `DRT_OFS_T0_RELOAD_LO;
        localparam logic [7:0] OFS_RH = g ? `DRT_OFS_T1_RELOAD_HI : `DRT_OFS_T0_RELOAD_HI;
        localparam logic [7:0] OFS_CL = g ? `DRT_OFS_T1_COUNT_LO : `DRT_OFS_T0_COUNT_LO;
        localparam logic [7:0] OFS_CH = g ? `DRT_OFS_T1_COUNT_HI : `DRT_OFS_T0_COUNT_HI;
        always_ff @(posedge CLK_SYS or negedge RESET_N) begin
            if (!RESET_N) begin
                reload_r[g] <= `DRT_RST_VALUE;
            end else if (wr_hit(BUS_REQ, OFS_RL)) begin
                reload_r[g] <= put_half(reload_r[g], 1'b0, BUS_REQ.wdata);
            end else if (wr_hit(BUS_REQ, OFS_RH)) begin
                reload_r[g] <= put_half(reload_r[g], 1'b1, BUS_REQ.wdata);
            end
        end
        always_ff @(posedge CLK_SYS or negedge RESET_N) begin
            if (!RESET_N) begin
                timer_live_count_r[g] <= `DRT_RST_VALUE;
            end else if (wr_hit(BUS_REQ, OFS_CL)) begin
                timer_live_count_r[g] <= put_half(timer_live_count_r[g], 1'b0,
                                                  BUS_REQ.wdata);
            end else if (wr_hit(BUS_REQ, OFS_CH)) begin
                timer_live_count_r[g] <= put_half(timer_live_count_r[g], 1'b1,
                                                  BUS_REQ.wdata);
            end else if (run_bits_r[g] && !run_prev_r[g]) begin
                timer_live_count_r[g] <= reload_r[g];
            end else if (underflow[g]) begin
                timer_live_count_r[g] <= reload_r[g];
            end else if (run_bits_r[g] && tick) begin
                timer_live_count_r[g] <= timer_live_count_r[g] - 32'h0000_0001;
            end
        end
    end

    // sticky status, set wins over write-one-to-clear so no underflow is lost
    assign clear_req = wr_hit(BUS_REQ, `DRT_OFS_IRQ_STATUS) ? BUS_REQ.wdata[1:0] : 2'h0;
    assign status_nxt = (status_r & ~clear_req) | underflow;
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            status_r <= `DRT_RST_STATUS;
        end else begin
            status_r <= status_nxt;
        end
    end

    // interrupt outputs; per-timer request is a one-cycle pulse
    always_comb begin
        if (underflow[0]) begin
            vec_nxt = `DRT_VEC_T0;
        end else if (underflow[1]) begin
            vec_nxt = `DRT_VEC_T1;
        end else begin
            vec_nxt = IRQ_VECTOR;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            TIMER_IRQ <= 2'h0;
            IRQ <= 1'b0;
            IRQ_VECTOR <= `DRT_VEC_T0;
        end else begin
            TIMER_IRQ <= underflow;
            IRQ <= |(status_nxt & mask_nxt);
            IRQ_VECTOR <= vec_nxt;
        end
    end

    // read port, data one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            RDATA <= 16'h0000;
        end else if (BUS_REQ.rd) begin
            case (BUS_REQ.addr)
                `DRT_OFS_CONFIG: RDATA <= {8'h00, tick_prescale_divider_r};
                `DRT_OFS_ENABLE: RDATA <= {14'h0000, run_bits_r};
                `DRT_OFS_T0_RELOAD_LO: RDATA <= get_half(reload_r[0], 1'b0);
                `DRT_OFS_T0_RELOAD_HI: RDATA <= get_half(reload_r[0], 1'b1);
                `DRT_OFS_T0_COUNT_LO: RDATA <= get_half(timer_live_count_r[0], 1'b0);
                `DRT_OFS_T0_COUNT_HI: RDATA <= get_half(timer_live_count_r[0], 1'b1);
                `DRT_OFS_T1_RELOAD_LO: RDATA <= get_half(reload_r[1], 1'b0);
                `DRT_OFS_T1_RELOAD_HI: RDATA <= get_half(reload_r[1], 1'b1);
                `DRT_OFS_T1_COUNT_LO: RDATA <= get_half(timer_live_count_r[1], 1'b0);
                `DRT_OFS_T1_COUNT_HI: RDATA <= get_half(timer_live_count_r[1], 1'b1);
                `DRT_OFS_IRQ_STATUS: RDATA <= {14'h0000, status_r};
                `DRT_OFS_IRQ_MASK: RDATA <= {14'h0000, mask_r};
                `DRT_OFS_VECTOR: RDATA <= {8'h00, IRQ_VECTOR};
                default: RDATA <= 16'h0000;
            endcase
        end else begin
            RDATA <= 16'h0000;
        end
    end
endmodule : drt_timer

// *** bench/drt_timer_chk.sv ***
// port assertions for the dual reload down timer
`timescale 1ns/1ps
module drt_timer_chk (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    // watched ports
    input wire drt_pkg::drt_bus_req_t BUS_REQ,
    input wire logic [15:0] RDATA,
    input wire logic [1:0] TIMER_IRQ,
    input wire logic IRQ,
    input wire logic [7:0] IRQ_VECTOR
);
    import drt_pkg::*;
    logic [1:0] en_r;
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RESET_N);
    // shadow of the run bits, so pulses can be tied to them
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) en_r <= 2'h0;
        else if (BUS_REQ.wr && BUS_REQ.addr == 8'h31) en_r <= BUS_REQ.wdata[1:0];
    end
    property p_rd_idle; !$past(BUS_REQ.rd) |-> RDATA == 16'h0000; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_rd_en;
        BUS_REQ.rd && BUS_REQ.addr == 8'h31 |=> RDATA == {14'h0, $past(en_r)};
    endproperty
    a_rd_en: assert property (p_rd_en) else $error("enable readback wrong");
    property p_rd_hole; BUS_REQ.rd && BUS_REQ.addr == 8'h20 |=> RDATA == 16'h0000; endproperty
    a_rd_hole: assert property (p_rd_hole) else $error("unmapped read not zero");
    property p_vec0; TIMER_IRQ[0] |-> IRQ_VECTOR == 8'h26; endproperty
    a_vec0: assert property (p_vec0) else $error("timer0 vector wrong");
    property p_vec1; TIMER_IRQ == 2'h2 |-> IRQ_VECTOR == 8'h27; endproperty
    a_vec1: assert property (p_vec1) else $error("timer1 vector wrong");
    property p_run0; TIMER_IRQ[0] |-> en_r[0] || $past(en_r[0]); endproperty
    a_run0: assert property (p_run0) else $error("stopped timer0 pulsed");
    property p_run1; TIMER_IRQ[1] |-> en_r[1] || $past(en_r[1]); endproperty
    a_run1: assert property (p_run1) else $error("stopped timer1 pulsed");
    property p_irq_up;
        $rose(IRQ) |-> TIMER_IRQ != 2'h0 || $past(BUS_REQ.wr) || $past(BUS_REQ.wr, 2);
    endproperty
    a_irq_up: assert property (p_irq_up) else $error("interrupt rose without cause");
    property p_irq_dn; $fell(IRQ) |-> $past(BUS_REQ.wr) || $past(BUS_REQ.wr, 2); endproperty
    a_irq_dn: assert property (p_irq_dn) else $error("interrupt fell without write");
    c_t0: cover property (TIMER_IRQ[0]);
    c_t1: cover property (TIMER_IRQ[1]);
    c_irq: cover property ($rose(IRQ));
endmodule : drt_timer_chk
bind drt_timer drt_timer_chk i_drt_timer_chk (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N),
    .BUS_REQ(BUS_REQ), .RDATA(RDATA), .TIMER_IRQ(TIMER_IRQ), .IRQ(IRQ), .IRQ_VECTOR(IRQ_VECTOR));

// *** bench/tb.sv ***
// self-checking bench for the dual reload down timer
`timescale 1ns/1ps
module tb;
    import drt_pkg::*;
    logic CLK_SYS = 1'b0;
    logic RESET_N = 1'b0;
    drt_bus_req_t req = '0;
    logic [15:0] rdata;
    logic [1:0] timer_irq;
    logic irq;
    logic [7:0] irq_vector;
    logic [15:0] v;
    int miscompares = 0;
    int checked = 0;
    int cycles = 0;
    int n;
    // rows: address, write data, expected readback
    logic [39:0] rows [11] = '{{8'h30, 16'h00A5, 16'h00A5}, {8'h31, 16'hFFFC, 16'h0000},
        {8'h34, 16'h1234, 16'h1234}, {8'h35, 16'hABCD, 16'hABCD}, {8'h38, 16'h5A5A, 16'h5A5A},
        {8'h39, 16'h0F0F, 16'h0F0F}, {8'h36, 16'h8001, 16'h8001}, {8'h3B, 16'h7FFE, 16'h7FFE},
        {8'h3D, 16'hFFFF, 16'h0003}, {8'h20, 16'hFFFF, 16'h0000}, {8'h3E, 16'h00FF, 16'h0026}};
    drt_timer i_drt_timer (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .BUS_REQ(req), .RDATA(rdata),
        .TIMER_IRQ(timer_irq), .IRQ(irq), .IRQ_VECTOR(irq_vector));
    initial begin
        forever #25 CLK_SYS = ~CLK_SYS;
    end
    task conclude;
        if (miscompares == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : conclude
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            miscompares++;
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge CLK_SYS) req <= '{a, d, 1'b1, 1'b0};
        @(posedge CLK_SYS) req <= '0;
    endtask : wr
    task rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge CLK_SYS) req <= '{a, 16'h0000, 1'b0, 1'b1};
        @(posedge CLK_SYS) req <= '0;
        #1 d = rdata;
    endtask : rd
    // cycles until the next underflow pulse of one timer, bounded
    task wait_pulse(input int b, output int c);
        c = 0;
        do begin
            @(posedge CLK_SYS);
            #1 c++;
        end while (timer_irq[b] !== 1'b1 && c < 100);
    endtask : wait_pulse
    always @(posedge CLK_SYS) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            conclude();
        end
    end
    // every mapped index up to the mask reads zero out of reset
    task read_all_zero;
        for (int a = 8'h30; a < 8'h3E; a++) begin
            rd(a[7:0], v);
            chk(v, 16'h0000);
        end
    endtask : read_all_zero
    initial begin
        repeat (20) @(posedge CLK_SYS);
        RESET_N <= 1'b1;
        chk(irq_vector, 8'h26);
        read_all_zero();
        foreach (rows[i]) begin
            wr(rows[i][39:32], rows[i][31:16]);
            rd(rows[i][39:32], v);
            chk(v, rows[i][15:0]);
        end
        // prescale 2, timer0 start 3: pulse every 8 cycles
        wr(8'h30, 16'h0001);
        wr(8'h34, 16'h0003);
        wr(8'h35, 16'h0000);
        wr(8'h3D, 16'h0001);
        wr(8'h31, 16'h0001);
        wait_pulse(0, n);
        wait_pulse(0, n);
        chk(n, 8);
        chk(irq_vector, 8'h26);
        #50 chk(irq, 1'b1);
        // one-off count of 9 takes 10 ticks: 19 or 20 cycles, by prescaler phase
        wr(8'h36, 16'h0009);
        wait_pulse(0, n);
        chk(n >= 19 && n <= 20, 1);
        wait_pulse(0, n);
        chk(n, 8);
        wr(8'h38, 16'h0001);
        wr(8'h39, 16'h0000);
        wr(8'h31, 16'h0002);
        wait_pulse(1, n);
        wait_pulse(1, n);
        chk(n, 4);
        chk(irq_vector, 8'h27);
        // timer0 is off now, so a written count must hold still
        wr(8'h36, 16'h0055);
        repeat (10) @(posedge CLK_SYS);
        rd(8'h36, v);
        chk(v, 16'h0055);
        wr(8'h31, 16'h0000);
        wr(8'h3D, 16'h0000);
        repeat (2) @(posedge CLK_SYS);
        #1 chk(irq, 1'b0);
        rd(8'h3C, v);
        chk(v, 16'h0003);
        wr(8'h3C, 16'h0003);
        rd(8'h3C, v);
        chk(v, 16'h0000);
        // mid-run reset with both timers running and the interrupt pending
        wr(8'h3D, 16'h0003);
        wr(8'h31, 16'h0003);
        repeat (20) @(posedge CLK_SYS);
        #1 chk(irq, 1'b1);
        @(posedge CLK_SYS) RESET_N <= 1'b0;
        @(posedge CLK_SYS);
        #1 chk({rdata, timer_irq, irq}, {16'h0000, 2'h0, 1'b0});
        chk(irq_vector, 8'h26);
        @(posedge CLK_SYS) RESET_N <= 1'b1;
        read_all_zero();
        conclude();
    end
endmodule : tb
